// ===== rtl/dmt_consts.svh
`ifndef DMT_CONSTS_SVH
`define DMT_CONSTS_SVH
// Register offsets (byte addresses, one word each)
`define DMT_OFS_CONTROL 8'h00
`define DMT_OFS_PRECLEAR 8'h04
`define DMT_OFS_SECOND 8'h08
`define DMT_OFS_STATUS 8'h0c
`define DMT_OFS_COUNT_LIMIT 8'h10
`define DMT_OFS_WINDOW 8'h14
`define DMT_OFS_INT_STATUS 8'h18
`define DMT_OFS_INT_CLEAR 8'h1c
`define DMT_OFS_INT_ENABLE 8'h20
// Field positions
`define DMT_BIT_ENABLE 15
`define DMT_KEY_HI 15
`define DMT_KEY_LO 8
`define DMT_BIT_FIRST_KEY_ERROR 7
`define DMT_BIT_SECOND_KEY_ERROR 6
`define DMT_BIT_EVENT 5
`define DMT_BIT_WINDOW 0
// Key values
`define DMT_FIRST_KEY 8'h40
`define DMT_SECOND_KEY 8'h08
// Reset values
`define DMT_LIMIT_RESET 32'h0000_1000
`define DMT_WINDOW_RESET 32'h0000_0800
// Interrupt bit positions
`define DMT_IRQ_FIRST_KEY_ERROR 0
`define DMT_IRQ_SECOND_KEY_ERROR 1
`define DMT_IRQ_EXPIRE 2
// Event request pulse length in cycles
`define DMT_EVENT_PULSE 4'h4
`endif

// ===== rtl/dmt_pkg.sv
package dmt_pkg;
  // Clear sequence states, Gray along idle -> armed -> done
  typedef enum logic [1:0] {
    DMT_IDLE = 2'b00,
    DMT_ARMED = 2'b01,
    DMT_DONE = 2'b11
  } dmt_state_t;
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dmt_req_t;
  // Status flags
  typedef struct packed {
    logic first_key_error;
    logic second_key_error;
    logic event_flag;
    logic window;
  } dmt_stat_t;
endpackage : dmt_pkg

// ===== rtl/dmt_pulse.sv
`timescale 1ns/1ps
// Stretches a one-cycle trigger into a pulse of LEN cycles
module dmt_pulse #(
  parameter logic [3:0] LEN = 4'h4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic trig,
  output logic pulse
);
  logic [3:0] cnt_reg; // Cycles left
  logic [3:0] cnt_next;
  // Load on trigger, count down otherwise
  always_comb begin
    if (trig) begin
      cnt_next = LEN;
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end else begin
      cnt_next = cnt_reg;
    end
  end
  // Register
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign pulse = (cnt_reg != 4'h0);
endmodule : dmt_pulse

// ===== rtl/dmt_core.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "dmt_consts.svh"
module dmt_core #(
  parameter logic [31:0] LIMIT_DEFAULT = `DMT_LIMIT_RESET,
  parameter logic [31:0] WINDOW_DEFAULT = `DMT_WINDOW_RESET
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic FUSE_TIMER_ENABLE,
  output logic [31:0] RDATA,
  output logic EVENT_REQ,
  output logic IRQ
);
  dmt_pkg::dmt_req_t req; // Bundled bus request
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // State
  logic enable_reg, enable_next; // Module enable
  logic fuse_seen_reg, fuse_seen_next; // Fuse sampled once
  logic [7:0] first_key_field_reg, first_key_field_next;
  dmt_pkg::dmt_state_t state_reg, state_next;
  logic [31:0] count_reg, count_next; // Timer counter
  logic [31:0] limit_reg, limit_next; // Expiry count
  logic [31:0] window_reg, window_next; // Window opening count
  dmt_pkg::dmt_stat_t stat_reg, stat_next;
  logic [2:0] int_stat_reg, int_stat_next; // Sticky events
  logic [2:0] int_en_reg, int_en_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic trig_reg, trig_next; // One-cycle timer event

  // Decoded strobes
  logic wr_ctl, wr_pre, wr_sec, wr_lim, wr_win, wr_clr, wr_ien;
  logic [7:0] key;
  logic expire, first_key_error_ev, second_key_error_ev, good2_ev, timer_event, win_open;
  logic pulse;
  assign key = req.wdata[`DMT_KEY_HI:`DMT_KEY_LO];
  assign wr_ctl = req.wr && req.addr == `DMT_OFS_CONTROL;
  assign wr_pre = req.wr && req.addr == `DMT_OFS_PRECLEAR;
  assign wr_sec = req.wr && req.addr == `DMT_OFS_SECOND;
  assign wr_lim = req.wr && req.addr == `DMT_OFS_COUNT_LIMIT;
  assign wr_win = req.wr && req.addr == `DMT_OFS_WINDOW;
  assign wr_clr = req.wr && req.addr == `DMT_OFS_INT_CLEAR;
  assign wr_ien = req.wr && req.addr == `DMT_OFS_INT_ENABLE;

  // Event decode
  assign win_open = enable_reg && count_reg >= window_reg;
  assign expire = enable_reg && count_reg >= limit_reg;
  assign first_key_error_ev = enable_reg && wr_pre && key != `DMT_FIRST_KEY;
  assign good2_ev = enable_reg && wr_sec && state_reg == dmt_pkg::DMT_ARMED
    && win_open && key == `DMT_SECOND_KEY;
  assign second_key_error_ev = enable_reg && wr_sec && !good2_ev;
  // Bad first key, a wrong, early or unarmed second key, or expiry is a timer event
  assign timer_event = expire || first_key_error_ev || second_key_error_ev;

  // Enable and fuse handling
  always_comb begin
    enable_next = enable_reg;
    fuse_seen_next = 1'b1;
    if (!fuse_seen_reg) begin
      enable_next = FUSE_TIMER_ENABLE;
    end else if (FUSE_TIMER_ENABLE) begin
      enable_next = 1'b1;
    end else if (wr_ctl) begin
      enable_next = req.wdata[`DMT_BIT_ENABLE];
    end
  end

  // Clear sequence and counter
  always_comb begin
    first_key_field_next = first_key_field_reg;
    state_next = state_reg;
    count_next = count_reg;
    if (!enable_reg) begin
      count_next = 32'h0;
      state_next = dmt_pkg::DMT_IDLE;
      first_key_field_next = 8'h00;
    end else if (timer_event) begin
      count_next = 32'h0;
      state_next = dmt_pkg::DMT_IDLE;
      first_key_field_next = 8'h00;
    end else if (good2_ev) begin
      count_next = 32'h0;
      state_next = dmt_pkg::DMT_IDLE;
      first_key_field_next = 8'h00;
    end else begin
      count_next = count_reg + 32'h1;
      if (wr_pre) begin
        first_key_field_next = key;
        state_next = dmt_pkg::DMT_ARMED;
      end
    end
  end

  // Status flags, hardware set and cleared only
  always_comb begin
    stat_next = stat_reg;
    stat_next.window = win_open;
    if (good2_ev) begin
      stat_next.first_key_error = 1'b0;
      stat_next.second_key_error = 1'b0;
      stat_next.event_flag = 1'b0;
    end
    if (first_key_error_ev) begin
      stat_next.first_key_error = 1'b1;
    end
    if (second_key_error_ev) begin
      stat_next.second_key_error = 1'b1;
    end
    if (timer_event) begin
      stat_next.event_flag = 1'b1;
    end
  end

  // Interrupt registers, set wins over clear
  always_comb begin
    int_en_next = wr_ien ? req.wdata[2:0] : int_en_reg;
    int_stat_next = int_stat_reg;
    if (wr_clr) begin
      int_stat_next = int_stat_reg & ~req.wdata[2:0];
    end
    if (first_key_error_ev) begin
      int_stat_next[`DMT_IRQ_FIRST_KEY_ERROR] = 1'b1;
    end
    if (second_key_error_ev) begin
      int_stat_next[`DMT_IRQ_SECOND_KEY_ERROR] = 1'b1;
    end
    if (expire) begin
      int_stat_next[`DMT_IRQ_EXPIRE] = 1'b1;
    end
    irq_next = |(int_stat_next & int_en_next);
    trig_next = timer_event;
  end

  // Configuration writes
  always_comb begin
    limit_next = wr_lim ? req.wdata : limit_reg;
    window_next = wr_win ? req.wdata : window_reg;
  end

  // Read mux, upper half zero on all registers except count limit and window
  always_comb begin
    rdata_next = 32'h0;
    if (req.rd) begin
      case (req.addr)
        `DMT_OFS_CONTROL: rdata_next[`DMT_BIT_ENABLE] = enable_reg;
        `DMT_OFS_PRECLEAR:
          rdata_next[`DMT_KEY_HI:`DMT_KEY_LO] = first_key_field_reg;
        `DMT_OFS_STATUS: begin
          rdata_next[`DMT_BIT_FIRST_KEY_ERROR] = stat_reg.first_key_error;
          rdata_next[`DMT_BIT_SECOND_KEY_ERROR] = stat_reg.second_key_error;
          rdata_next[`DMT_BIT_EVENT] = stat_reg.event_flag;
          rdata_next[`DMT_BIT_WINDOW] = stat_reg.window;
        end
        `DMT_OFS_COUNT_LIMIT: rdata_next = limit_reg;
        `DMT_OFS_WINDOW: rdata_next = window_reg;
        `DMT_OFS_INT_STATUS: rdata_next[2:0] = int_stat_reg;
        `DMT_OFS_INT_ENABLE: rdata_next[2:0] = int_en_reg;
        default: rdata_next = 32'h0; // Unmapped and write-only read 0
      endcase
    end
  end

  // Registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      enable_reg <= 1'b0;
      fuse_seen_reg <= 1'b0;
      first_key_field_reg <= 8'h00;
      state_reg <= dmt_pkg::DMT_IDLE;
      count_reg <= 32'h0;
      limit_reg <= LIMIT_DEFAULT;
      window_reg <= WINDOW_DEFAULT;
      stat_reg <= '0;
      int_stat_reg <= 3'h0;
      int_en_reg <= 3'h0;
      rdata_reg <= 32'h0;
      irq_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      fuse_seen_reg <= fuse_seen_next;
      first_key_field_reg <= first_key_field_next;
      state_reg <= state_next;
      count_reg <= count_next;
      limit_reg <= limit_next;
      window_reg <= window_next;
      stat_reg <= stat_next;
      int_stat_reg <= int_stat_next;
      int_en_reg <= int_en_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      trig_reg <= trig_next;
    end
  end

  // Event request stretcher
  dmt_pulse #(.LEN(`DMT_EVENT_PULSE)) u_pulse (
    .clk(CLK),
    .rst(RST),
    .trig(trig_reg),
    .pulse(pulse)
  );

  // Output flops
  always_ff @(posedge CLK) begin
    if (RST) begin
      EVENT_REQ <= 1'b0;
    end else begin
      EVENT_REQ <= pulse;
    end
  end
  assign RDATA = rdata_reg;
  assign IRQ = irq_reg;

  // Assertions
  // Counter held at zero while the module is off
  a_disabled_idle: assert property (
    @(posedge CLK) disable iff (RST)
    !enable_reg |=> count_reg == 32'h0)
    else $error("counter ran while disabled");
  // Enable taken from the fuse on the first edge after reset
  a_fuse_load: assert property (
    @(posedge CLK) disable iff (RST)
    !fuse_seen_reg |=> enable_reg == $past(FUSE_TIMER_ENABLE))
    else $error("enable not loaded from fuse");
  // Fuse at one keeps the module on
  a_fuse_forces_on: assert property (
    @(posedge CLK) disable iff (RST)
    fuse_seen_reg && FUSE_TIMER_ENABLE |=> enable_reg)
    else $error("fuse did not force enable");
  // Software write lands while the fuse is clear
  a_soft_enable: assert property (
    @(posedge CLK) disable iff (RST)
    fuse_seen_reg && !FUSE_TIMER_ENABLE && wr_ctl |=>
    enable_reg == $past(WDATA[`DMT_BIT_ENABLE]))
    else $error("enable write lost");
  // Without a write the enable holds
  a_enable_hold: assert property (
    @(posedge CLK) disable iff (RST)
    fuse_seen_reg && !FUSE_TIMER_ENABLE && !wr_ctl |=>
    $stable(enable_reg))
    else $error("enable changed without a write");
  // Valid first key arms the clear
  a_good_arm: assert property (
    @(posedge CLK) disable iff (RST)
    enable_reg && wr_pre && key == `DMT_FIRST_KEY && !expire |=>
    state_reg == dmt_pkg::DMT_ARMED)
    else $error("valid key did not arm");
  // Any other first key leaves the clear unarmed
  a_bad_key_idle: assert property (
    @(posedge CLK) disable iff (RST)
    enable_reg && wr_pre && key != `DMT_FIRST_KEY |=>
    state_reg == dmt_pkg::DMT_IDLE)
    else $error("wrong first key armed");
  // Wrong first key flagged as error and event
  a_first_key_error_set: assert property (
    @(posedge CLK) disable iff (RST)
    first_key_error_ev |=> stat_reg.first_key_error && stat_reg.event_flag)
    else $error("bad first key not flagged");
  // Event or good second key empties the key field
  a_key_clear: assert property (
    @(posedge CLK) disable iff (RST)
    enable_reg && (timer_event || good2_ev) |=>
    first_key_field_reg == 8'h00)
    else $error("first key field not cleared");
  // Wrong second key flagged
  a_second_key_error_set: assert property (
    @(posedge CLK) disable iff (RST)
    second_key_error_ev |=> stat_reg.second_key_error)
    else $error("bad second key not flagged");
  // Expiry raises the event flag
  a_event_flag: assert property (
    @(posedge CLK) disable iff (RST)
    expire |=> stat_reg.event_flag)
    else $error("expiry not flagged");
  // Window bit follows an open window
  a_window_bit: assert property (
    @(posedge CLK) disable iff (RST)
    win_open |=> stat_reg.window)
    else $error("window bit missing");
  // Window bit drops once the window shuts
  a_window_shut: assert property (
    @(posedge CLK) disable iff (RST)
    !win_open |=> !stat_reg.window)
    else $error("window bit stuck");
  // Flags move only on hardware events
  a_status_ro: assert property (
    @(posedge CLK) disable iff (RST)
    !timer_event && !good2_ev |=>
    $stable({stat_reg.first_key_error, stat_reg.second_key_error, stat_reg.event_flag}))
    else $error("status flag changed without cause");
  // Event request stands four cycles, starting three cycles after the timer event
  a_event_req: assert property (
    @(posedge CLK) disable iff (RST)
    timer_event |-> ##3 EVENT_REQ [*4])
    else $error("event request too short");
  // Upper half of the control, preclear, second and status registers reads zero
  a_upper_zero: assert property (
    @(posedge CLK) disable iff (RST)
    $past(RD) && ($past(ADDR) <= `DMT_OFS_STATUS) |->
    RDATA[31:16] == 16'h0)
    else $error("upper register bits not zero");
endmodule : dmt_core

// ===== sim/testbench.sv
`timescale 1ns/1ps
`include "dmt_consts.svh"
module testbench;
  logic clk, rst, wr, rd, fuse, evt, irq; // Bench-driven pins and the evt, irq outputs
  logic [7:0] addr; // Register address
  logic [31:0] wdata, rdata, last; // Bus data
  logic [31:0] exp_q[$], msk_q[$]; // Expected read notes
  logic rd_q; // Read taken last edge
  logic hit; // Event pulse seen
  int err_count = 0, n_tests = 0, cyc = 0, i; // Counters
  int seed = 32'he368b4b4; // Random seed
  logic [7:0] key; // Random bad key
  dmt_core #(.LIMIT_DEFAULT(32'h40), .WINDOW_DEFAULT(32'h10)) i_dmt_core (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .FUSE_TIMER_ENABLE(fuse), .RDATA(rdata), .EVENT_REQ(evt), .IRQ(irq));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Compare one value and count it
  task automatic check(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask : check
  // Verdict and end of run
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // One-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  // One-cycle read; expectation noted for the monitor
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    last = rdata;
  endtask : bus_rd
  // Watch the event request for n cycles
  task automatic watch_ev(input int n);
    hit = 1'b0;
    repeat (n) @(negedge clk) if (evt === 1'b1) hit = 1'b1;
  endtask : watch_ev
  // Reset held for 16 cycles
  task automatic do_reset(input logic f);
    rst <= 1'b1;
    fuse <= f;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset
  // Arm, wait for the open window, send the second key
  task automatic good_clear;
    bus_wr(`DMT_OFS_PRECLEAR, 32'h0000_4000);
    last = 32'h0;
    for (i = 0; i < 60 && last[0] !== 1'b1; i++)
      bus_rd(`DMT_OFS_STATUS, 32'h0, 32'hffff_ff00);
    bus_wr(`DMT_OFS_SECOND, 32'h0000_0800);
  endtask : good_clear
  // Note which edge took a read
  always @(posedge clk) rd_q <= rd;
  // Compare read data against the oldest note
  always @(negedge clk) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) check("rnote", 32'h1, 32'h0);
      else check("rdata", rdata & msk_q[0], exp_q[0] & msk_q[0]);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
      if (msk_q.size() != 0) void'(msk_q.pop_front());
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // Main sequence
  initial begin
    {rst, wr, rd, fuse, addr, wdata} = '0;
    do_reset(1'b0);
    bus_rd(`DMT_OFS_CONTROL, 32'h0, 32'hffff_ffff);
    watch_ev(80);
    check("idle_ev", hit, 1'b0);
    bus_wr(`DMT_OFS_CONTROL, 32'hffff_ffff);
    bus_rd(`DMT_OFS_CONTROL, 32'h8000, 32'hffff_ffff);
    bus_wr(`DMT_OFS_INT_ENABLE, 32'h7);
    bus_wr(`DMT_OFS_PRECLEAR, 32'h0000_4000);
    bus_rd(`DMT_OFS_PRECLEAR, 32'h4000, 32'hffff_ffff);
    good_clear();
    bus_rd(`DMT_OFS_PRECLEAR, 32'h0, 32'hffff_ffff);
    bus_rd(`DMT_OFS_STATUS, 32'h0, 32'hffff_ffe1);
    // Wrong first key after arming
    bus_wr(`DMT_OFS_PRECLEAR, 32'h0000_4000);
    key = 8'($random(seed));
    if (key == 8'h40) key = 8'h41;
    bus_wr(`DMT_OFS_PRECLEAR, {16'h0, key, 8'h0});
    watch_ev(8);
    check("bad_ev", hit, 1'b1);
    bus_rd(`DMT_OFS_STATUS, 32'ha0, 32'hffff_ffe0);
    bus_rd(`DMT_OFS_PRECLEAR, 32'h0, 32'hffff_ffff);
    check("irq_on", irq, 1'b1);
    bus_rd(`DMT_OFS_INT_STATUS, 32'h1, 32'h1);
    bus_wr(`DMT_OFS_STATUS, 32'h0);
    bus_rd(`DMT_OFS_STATUS, 32'ha0, 32'hffff_ffe0);
    bus_wr(`DMT_OFS_INT_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    @(negedge clk) check("irq_off", irq, 1'b0);
    bus_wr(`DMT_OFS_INT_CLEAR, 32'h7);
    bus_rd(`DMT_OFS_INT_STATUS, 32'h0, 32'h1);
    bus_wr(`DMT_OFS_INT_ENABLE, 32'h7);
    good_clear();
    bus_rd(`DMT_OFS_STATUS, 32'h0, 32'hffff_ffe0);
    // Wrong second key after arming
    bus_wr(`DMT_OFS_PRECLEAR, 32'h0000_4000);
    bus_wr(`DMT_OFS_SECOND, 32'h0000_0900);
    bus_rd(`DMT_OFS_STATUS, 32'h40, 32'hffff_ffc0);
    // Clear once, then let the counter run out
    good_clear();
    watch_ev(80);
    check("exp_ev", hit, 1'b1);
    bus_rd(`DMT_OFS_STATUS, 32'h20, 32'hffff_ff20);
    // Fuse-forced enable, reset raised on a rising edge
    @(posedge clk);
    do_reset(1'b1);
    bus_rd(`DMT_OFS_COUNT_LIMIT, 32'h40, 32'hffff_ffff);
    bus_wr(`DMT_OFS_WINDOW, 32'h0000_0018);
    bus_rd(`DMT_OFS_WINDOW, 32'h18, 32'hffff_ffff);
    bus_rd(`DMT_OFS_CONTROL, 32'h8000, 32'hffff_ffff);
    bus_wr(`DMT_OFS_CONTROL, 32'h0);
    bus_rd(`DMT_OFS_CONTROL, 32'h8000, 32'hffff_ffff);
    bus_wr(8'h24, $random(seed));
    bus_rd(8'h24, 32'h0, 32'hffff_ffff);
    bus_rd(`DMT_OFS_SECOND, 32'h0, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule : testbench
